/* logic/reset_boot_pkg.sv */
`default_nettype none
package reset_boot_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IMASK = 4'h8;
    localparam logic [3:0] ADDR_MODE_STATUS = 4'hC;

    localparam int CTRL_CLK_DIS_BIT = 0;
    localparam int CTRL_SIX_IRQ_BIT = 1;
    localparam int CTRL_FLAG_DIR_BIT = 2;
    localparam int CTRL_FLAG_VAL_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    localparam int IMASK_W = 10;
    localparam int MODE_STATUS_REG_W = 7;
    localparam logic [IMASK_W-1:0] IMASK_RESET = 10'h000;
    localparam logic [MODE_STATUS_REG_W-1:0] MODE_STATUS_REG_RESET = 7'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // counts and addresses
    // ------------------------------------------------------------
    localparam int PLL_LOCK_INPUT_CYCLES = 2000;
    localparam int BOOT_WORD_COUNT = 32;
    localparam logic [15:0] FIRST_FETCH_ADDR = 16'h0000;

    // ------------------------------------------------------------
    // mode pins c, b, a
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_BYTE_FULL = 3'h0;
    localparam logic [2:0] MODE_NO_BOOT = 3'h2;
    localparam logic [2:0] MODE_BYTE_HOST = 3'h4;
    localparam logic [2:0] MODE_INTERNAL_DMA_PORT_HOST = 3'h5;

    typedef enum logic [2:0] {
        ST_LOCK = 3'b000,
        ST_RESET = 3'b001,
        ST_BUSWAIT = 3'b011,
        ST_BOOT_BYTE = 3'b010,
        ST_RUN = 3'b110,
        ST_BOOT_HOST = 3'b111
    } boot_state_type;

endpackage
`default_nettype wire

/* logic/reset_boot_mode_control.sv */
// Summary of operation
// - instruction clock runs at twice input clock
// - cycle clock output, gated by disable bit
// - later resets: clock runs, no wait
// - hold reset for 2000 input clocks
// - reset empties stacks, masks interrupts, clears status
// - no bus request: boot before running
// - first fetch from program address zero
// - memory mode from strap on flag two
// - mode 000: byte boot 32 words, full
// - mode 010: no boot, external zero
// - mode 100: byte boot 32 words, host
// - mode 101: wait for internal write to zero
// - pin D picks acknowledge output type
// - host mode: full data, one address bit
// - four or six interrupts by serial config
// - flag pin free after reset
// - pin D high: open-source acknowledge
`timescale 1ns/1ps
`default_nettype none
module reset_boot_mode_control
    import reset_boot_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = PLL_LOCK_INPUT_CYCLES,
    parameter int BOOT_WORDS = BOOT_WORD_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic input_clock,
    input wire logic reset_pin_n,
    input wire logic mode_a,
    input wire logic mode_b,
    input wire logic mode_d,
    input wire logic flag_pin_two_i,
    output logic flag_pin_two_o,
    output logic flag_pin_two_oe,
    input wire logic bus_request,
    input wire logic byte_dma_word_done,
    input wire logic internal_dma_port_write,
    input wire logic internal_dma_port_addr_zero,
    input wire logic host_ack_req,
    output logic host_access_ack_o,
    output logic host_access_ack_oe,
    output logic cycle_clock_out,
    output logic core_reset_n,
    output logic stack_clear,
    output logic core_run,
    output logic byte_dma_boot_req,
    output logic fetch_external,
    output logic [15:0] fetch_addr,
    output logic host_mode,
    output logic six_irq_mode,
    output logic [IMASK_W-1:0] imask,
    output logic [MODE_STATUS_REG_W-1:0] mode_status,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    localparam int LOCK_W = $clog2(PLL_LOCK_CYCLES + 1);
    localparam int WORD_W = $clog2(BOOT_WORDS + 1);
    localparam logic [LOCK_W-1:0] LOCK_MAX = LOCK_W'(PLL_LOCK_CYCLES - 1);
    localparam logic [WORD_W-1:0] WORD_MAX = WORD_W'(BOOT_WORDS - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] meta;
        logic [5:0] sync;
        logic inclk_prev;
        boot_state_type state;
        logic [LOCK_W-1:0] lock_cnt;
        logic [WORD_W-1:0] word_cnt;
        logic [3:0] mode;
        logic [3:0] ctrl;
        logic [IMASK_W-1:0] imask;
        logic [MODE_STATUS_REG_W-1:0] mode_status_reg;
        logic clk_out;
        logic core_reset_n;
        logic stack_clear;
        logic core_run;
        logic byte_boot;
        logic fetch_ext;
        logic host_mode;
        logic flag_o;
        logic flag_oe;
        logic ack_o;
        logic ack_oe;
        logic waitreq;
        logic [31:0] rdata;
    } state_type;

    state_type s_q;
    state_type s_d;
    logic mreset;
    logic inclk_rise;
    logic in_reset_d;
    logic [2:0] mode_cba;

    always_comb begin
        s_d = s_q;
        mreset = !s_q.sync[5];
        inclk_rise = s_q.sync[4] && !s_q.inclk_prev;
        mode_cba = s_q.mode[2:0];
        // pin synchronisers: reset, input clock, flag, a, b, d
        s_d.meta = {reset_pin_n, input_clock, flag_pin_two_i,
                    mode_a, mode_b, mode_d};
        s_d.sync = s_q.meta;
        s_d.inclk_prev = s_q.sync[4];
        // cycle clock out: ref_clk / 2, held low while disabled
        s_d.clk_out = !s_q.ctrl[CTRL_CLK_DIS_BIT] &&
                      !s_q.clk_out;
        // power-up, reset and boot sequence
        unique case (s_q.state)
            ST_LOCK: begin
                if (inclk_rise) begin
                    if (s_q.lock_cnt == LOCK_MAX) begin
                        s_d.state = ST_RESET;
                    end else begin
                        s_d.lock_cnt = s_q.lock_cnt + 1'b1;
                    end
                end
            end
            ST_RESET: begin
                if (!mreset) begin
                    s_d.state = ST_BUSWAIT;
                end
            end
            ST_BUSWAIT: begin
                if (!bus_request) begin
                    if (mode_cba == MODE_BYTE_FULL ||
                        mode_cba == MODE_BYTE_HOST) begin
                        s_d.state = ST_BOOT_BYTE;
                        s_d.word_cnt = '0;
                    end else if (mode_cba == MODE_INTERNAL_DMA_PORT_HOST) begin
                        s_d.state = ST_BOOT_HOST;
                    end else begin
                        s_d.state = ST_RUN;
                    end
                end
            end
            ST_BOOT_BYTE: begin
                if (byte_dma_word_done) begin
                    if (s_q.word_cnt == WORD_MAX) begin
                        s_d.state = ST_RUN;
                    end else begin
                        s_d.word_cnt = s_q.word_cnt + 1'b1;
                    end
                end
            end
            ST_BOOT_HOST: begin
                if (internal_dma_port_write && internal_dma_port_addr_zero) begin
                    s_d.state = ST_RUN;
                end
            end
            ST_RUN: s_d.state = ST_RUN;
            default: s_d.state = ST_RESET;
        endcase
        // later resets skip the lock wait
        if (mreset && s_q.state != ST_LOCK) begin
            s_d.state = ST_RESET;
        end
        in_reset_d = (s_d.state == ST_LOCK) || (s_d.state == ST_RESET);
        // mode straps follow the pins until reset lets go
        if (in_reset_d) begin
            s_d.mode = {s_q.sync[0], s_q.sync[3],
                        s_q.sync[1], s_q.sync[2]};
        end
        // register bus: one wait state per access
        if ((avs_read || avs_write) && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            unique case (avs_address)
                ADDR_CTRL: s_d.rdata = 32'(s_q.ctrl);
                ADDR_STATUS: s_d.rdata = 32'({s_q.state, s_q.core_run,
                                              s_q.host_mode, s_q.mode});
                ADDR_IMASK: s_d.rdata = 32'(s_q.imask);
                ADDR_MODE_STATUS: s_d.rdata = 32'(s_q.mode_status_reg);
                default: s_d.rdata = READ_ZERO;
            endcase
        end else begin
            s_d.waitreq = 1'b1;
        end
        if (avs_write && !s_q.waitreq) begin
            unique case (avs_address)
                ADDR_CTRL: begin
                    if (avs_byteenable[0]) begin
                        s_d.ctrl = avs_writedata[3:0];
                    end
                end
                ADDR_IMASK: begin
                    if (avs_byteenable[0]) begin
                        s_d.imask[7:0] = avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        s_d.imask[9:8] = avs_writedata[9:8];
                    end
                end
                ADDR_MODE_STATUS: begin
                    if (avs_byteenable[0]) begin
                        s_d.mode_status_reg = avs_writedata[MODE_STATUS_REG_W-1:0];
                    end
                end
                default: s_d.ctrl = s_q.ctrl;
            endcase
        end
        // master reset effects win over software writes
        if (in_reset_d) begin
            s_d.imask = IMASK_RESET;
            s_d.mode_status_reg = MODE_STATUS_REG_RESET;
        end
        s_d.core_reset_n = !in_reset_d;
        s_d.stack_clear = in_reset_d;
        s_d.core_run = (s_d.state == ST_RUN);
        s_d.byte_boot = (s_d.state == ST_BOOT_BYTE);
        s_d.fetch_ext = (s_d.state == ST_RUN) &&
                        (s_d.mode[2:0] == MODE_NO_BOOT);
        s_d.host_mode = s_d.mode[2];
        // flag pin is released to software only after reset
        s_d.flag_oe = !in_reset_d &&
                      s_q.ctrl[CTRL_FLAG_DIR_BIT];
        s_d.flag_o = s_q.ctrl[CTRL_FLAG_VAL_BIT];
        // acknowledge driver type from pin d
        if (in_reset_d || !s_d.mode[2]) begin
            s_d.ack_o = 1'b0;
            s_d.ack_oe = 1'b0;
        end else if (!s_d.mode[3]) begin
            s_d.ack_o = host_ack_req;
            s_d.ack_oe = 1'b1;
        end else begin
            s_d.ack_o = 1'b1;
            s_d.ack_oe = host_ack_req;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.state <= ST_LOCK;
            s_q.ctrl <= CTRL_RESET;
            s_q.imask <= IMASK_RESET;
            s_q.mode_status_reg <= MODE_STATUS_REG_RESET;
            s_q.stack_clear <= 1'b1;
            s_q.waitreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cycle_clock_out = s_q.clk_out;
    assign core_reset_n = s_q.core_reset_n;
    assign stack_clear = s_q.stack_clear;
    assign core_run = s_q.core_run;
    assign byte_dma_boot_req = s_q.byte_boot;
    assign fetch_external = s_q.fetch_ext;
    assign fetch_addr = FIRST_FETCH_ADDR;
    assign host_mode = s_q.host_mode;
    assign six_irq_mode = s_q.ctrl[CTRL_SIX_IRQ_BIT];
    assign imask = s_q.imask;
    assign mode_status = s_q.mode_status_reg;
    assign flag_pin_two_o = s_q.flag_o;
    assign flag_pin_two_oe = s_q.flag_oe;
    assign host_access_ack_o = s_q.ack_o;
    assign host_access_ack_oe = s_q.ack_oe;
    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    property p_clk_toggle;
        !s_q.ctrl[CTRL_CLK_DIS_BIT] |=>
            cycle_clock_out != $past(cycle_clock_out);
    endproperty
    a_clk_toggle: assert property (p_clk_toggle)
        else $error("cycle clock did not toggle");
    property p_clk_gate;
        s_q.ctrl[CTRL_CLK_DIS_BIT] |=> !cycle_clock_out;
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("cycle clock not gated off");
    property p_no_relock;
        s_q.state != ST_LOCK |=> s_q.state != ST_LOCK;
    endproperty
    a_no_relock: assert property (p_no_relock)
        else $error("lock wait repeated after power-up");
    property p_lock_count;
        (s_q.state != ST_LOCK && $past(s_q.state) == ST_LOCK) |->
            $past(s_q.lock_cnt) == LOCK_MAX;
    endproperty
    a_lock_count: assert property (p_lock_count)
        else $error("left lock wait early");
    property p_reset_clear;
        mreset |=> (imask == IMASK_RESET && mode_status == MODE_STATUS_REG_RESET
                    && stack_clear && !core_run);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("master reset effects missing");
    property p_first_fetch;
        $rose(core_run) |-> !byte_dma_boot_req &&
            fetch_addr == FIRST_FETCH_ADDR;
    endproperty
    a_first_fetch: assert property (p_first_fetch)
        else $error("first fetch not at zero");
    property p_byte_hold;
        (s_q.state == ST_BOOT_BYTE && !byte_dma_word_done && !mreset) |=>
            !core_run && byte_dma_boot_req;
    endproperty
    a_byte_hold: assert property (p_byte_hold)
        else $error("ran before byte boot finished");
    property p_no_boot;
        (s_q.state == ST_BUSWAIT && !bus_request && !mreset &&
         mode_cba == MODE_NO_BOOT) |=> core_run && fetch_external;
    endproperty
    a_no_boot: assert property (p_no_boot)
        else $error("no-boot mode did not start externally");
    property p_internal_dma_port_hold;
        (s_q.state == ST_BOOT_HOST && !(internal_dma_port_write && internal_dma_port_addr_zero))
            |=> !core_run;
    endproperty
    a_internal_dma_port_hold: assert property (p_internal_dma_port_hold)
        else $error("ran before internal write to zero");
    property p_ack_type;
        (!in_reset_d && s_d.mode[2] && s_d.mode[3]) |=>
            (host_access_ack_o && host_access_ack_oe == $past(host_ack_req));
    endproperty
    a_ack_type: assert property (p_ack_type)
        else $error("open-source acknowledge misdriven");
    property p_flag_idle;
        s_q.state == ST_RESET |-> !flag_pin_two_oe && !core_run;
    endproperty
    a_flag_idle: assert property (p_flag_idle)
        else $error("flag driven or running in reset");
    property p_mode_hold;
        (s_q.state == ST_RUN && $past(s_q.state) == ST_RUN) |->
            $stable(s_q.mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed outside reset");
    c_byte_boot: cover property (s_q.state == ST_BOOT_BYTE ##1
                                 s_q.state == ST_RUN);
    c_internal_dma_port_boot: cover property (s_q.state == ST_BOOT_HOST ##1
                                 s_q.state == ST_RUN);
    c_no_boot: cover property ($rose(fetch_external));
    c_late_reset: cover property (s_q.state == ST_RUN ##1
                                  s_q.state == ST_RESET);

endmodule // reset_boot_mode_control
`default_nettype wire

/* verification/boot_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module boot_partner
    import reset_boot_pkg::*;
#(
    parameter int WORDS = BOOT_WORD_COUNT
) (
    input wire logic ref_clk,
    input wire logic hold_reset,
    input wire logic [3:0] strap,
    input wire logic [1:0] gap,
    input wire logic byte_dma_boot_req,
    input wire logic flag_pin_two_o,
    input wire logic flag_pin_two_oe,
    output logic input_clock,
    output logic reset_pin_n,
    output logic mode_a,
    output logic mode_b,
    output logic mode_d,
    output logic flag_pin_two_i,
    output logic byte_dma_word_done,
    output logic [7:0] words_sent
);
    // ------------------------------------------------------------
    // reset source, strap drivers, boot memory
    // ------------------------------------------------------------
    logic [1:0] rel_q;
    logic [1:0] gap_q;

    assign mode_a = strap[0];
    assign mode_b = strap[1];
    assign mode_d = strap[3];

    initial begin
        input_clock = 1'b0;
        forever #11 input_clock = ~input_clock;
    end

    always @(posedge ref_clk) begin
        reset_pin_n <= ~hold_reset;
        rel_q <= reset_pin_n ? rel_q + {1'b0, rel_q != 2'h3} : 2'h0;
        // strap driver turns off two cycles after release; pin then floats
        if (!reset_pin_n || rel_q < 2'h2) begin
            flag_pin_two_i <= strap[2];
        end else if (flag_pin_two_oe) begin
            flag_pin_two_i <= flag_pin_two_o;
        end else begin
            flag_pin_two_i <= ~flag_pin_two_i;
        end
        byte_dma_word_done <= 1'b0;
        if (!reset_pin_n) begin
            words_sent <= 8'h00;
            gap_q <= 2'h0;
        end else if (byte_dma_boot_req && words_sent < 8'(WORDS)) begin
            gap_q <= (gap_q == gap) ? 2'h0 : gap_q + 2'h1;
            if (gap_q == gap) begin
                byte_dma_word_done <= 1'b1;
                words_sent <= words_sent + 8'h01;
            end
        end
    end
endmodule // boot_partner
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import reset_boot_pkg::*;
;
    logic ref_clk, rst_n, input_clock, reset_pin_n, mode_a, mode_b, mode_d;
    logic flag_pin_two_i, flag_pin_two_o, flag_pin_two_oe, bus_request;
    logic byte_dma_word_done, internal_dma_port_write, internal_dma_port_addr_zero, host_ack_req;
    logic host_access_ack_o, host_access_ack_oe, cycle_clock_out;
    logic core_reset_n, stack_clear, core_run, byte_dma_boot_req;
    logic fetch_external, host_mode, six_irq_mode, hold_reset;
    logic avs_read, avs_write, avs_waitrequest;
    logic [15:0] fetch_addr;
    logic [IMASK_W-1:0] imask;
    logic [MODE_STATUS_REG_W-1:0] mode_status;
    logic [3:0] avs_address, avs_byteenable, strap;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0] gap;
    logic [7:0] words_sent;
    logic [5:0] modes [6] = '{6'h10, 6'h12, 6'h34, 6'h15, 6'h1C, 6'h1D};
    int n_errors = 0;
    int samples_checked = 0;

    reset_boot_mode_control #(.PLL_LOCK_CYCLES(4),
        .BOOT_WORDS(BOOT_WORD_COUNT)) i_reset_boot_mode_control (
        .ref_clk(ref_clk), .rst_n(rst_n), .input_clock(input_clock),
        .reset_pin_n(reset_pin_n), .mode_a(mode_a), .mode_b(mode_b),
        .mode_d(mode_d), .flag_pin_two_i(flag_pin_two_i),
        .flag_pin_two_o(flag_pin_two_o), .flag_pin_two_oe(flag_pin_two_oe),
        .bus_request(bus_request), .byte_dma_word_done(byte_dma_word_done),
        .internal_dma_port_write(internal_dma_port_write), .internal_dma_port_addr_zero(internal_dma_port_addr_zero),
        .host_ack_req(host_ack_req), .host_access_ack_o(host_access_ack_o),
        .host_access_ack_oe(host_access_ack_oe),
        .cycle_clock_out(cycle_clock_out), .core_reset_n(core_reset_n),
        .stack_clear(stack_clear), .core_run(core_run),
        .byte_dma_boot_req(byte_dma_boot_req),
        .fetch_external(fetch_external), .fetch_addr(fetch_addr),
        .host_mode(host_mode), .six_irq_mode(six_irq_mode), .imask(imask),
        .mode_status(mode_status), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    boot_partner #(.WORDS(BOOT_WORD_COUNT)) i_boot_partner (
        .ref_clk(ref_clk), .hold_reset(hold_reset), .strap(strap),
        .gap(gap), .byte_dma_boot_req(byte_dma_boot_req),
        .flag_pin_two_o(flag_pin_two_o), .flag_pin_two_oe(flag_pin_two_oe),
        .input_clock(input_clock), .reset_pin_n(reset_pin_n),
        .mode_a(mode_a), .mode_b(mode_b), .mode_d(mode_d),
        .flag_pin_two_i(flag_pin_two_i),
        .byte_dma_word_done(byte_dma_word_done), .words_sent(words_sent));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic fail_wait;
        n_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        summarize();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    function automatic logic cond(input int w);
        case (w)
            0: cond = core_run;
            1: cond = byte_dma_boot_req;
            default: cond = words_sent == 8'(BOOT_WORD_COUNT - 1);
        endcase
    endfunction

    task automatic wait_for(input int w);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge ref_clk);
            if (cond(w) === 1'b1) break;
        end
        if (i == 400) fail_wait();
    endtask

    // avalon transfer: hold until waitrequest low, then release
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
        if (i == 20) fail_wait();
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic toggles(input int exp);
        int n;
        logic p;
        n = 0;
        p = cycle_clock_out;
        repeat (8) begin
            @(posedge ref_clk);
            if (cycle_clock_out !== p) n++;
            p = cycle_clock_out;
        end
        chk(n, exp);
    endtask

    // ------------------------------------------------------------
    // one reset and boot per strap setting
    // ------------------------------------------------------------
    task automatic run_mode(input logic [5:0] cfg);
        logic [3:0] s;
        s = cfg[3:0];
        bus(1'b1, ADDR_IMASK, 32'h0000_03FF);
        bus(1'b1, ADDR_MODE_STATUS, 32'h0000_007F);
        hold_reset <= 1'b1;
        strap <= s;
        gap <= cfg[5:4];
        bus_request <= 1'b1;
        tick(10);
        chk({imask, mode_status}, 32'h0000_0000);
        chk({core_reset_n, stack_clear, core_run, flag_pin_two_oe,
             host_access_ack_oe, byte_dma_boot_req}, 6'h10);
        rdchk(ADDR_IMASK, 32'h0000_0000);
        rdchk(ADDR_MODE_STATUS, 32'h0000_0000);
        toggles(8);
        hold_reset <= 1'b0;
        tick(12);
        chk({core_run, byte_dma_boot_req}, 2'h0);
        bus_request <= 1'b0;
        if (s[1:0] == 2'h0) begin
            wait_for(1);
            wait_for(2);
            chk(core_run, 1'b0);
            wait_for(0);
            chk(words_sent, BOOT_WORD_COUNT);
            chk(byte_dma_boot_req, 1'b0);
        end else if (s[1]) begin
            wait_for(0);
        end else begin
            tick(1);
            internal_dma_port_write <= 1'b1;
            tick(1);
            internal_dma_port_write <= 1'b0;
            tick(6);
            chk(core_run, 1'b0);
            internal_dma_port_write <= 1'b1;
            internal_dma_port_addr_zero <= 1'b1;
            tick(1);
            internal_dma_port_write <= 1'b0;
            internal_dma_port_addr_zero <= 1'b0;
            wait_for(0);
        end
        chk(fetch_external, s[2:0] == MODE_NO_BOOT);
        chk(fetch_addr, FIRST_FETCH_ADDR);
        chk(host_mode, s[2]);
        tick(8);
        rdchk(ADDR_STATUS, {23'h0, ST_RUN, 1'b1, s[2], s});
        host_ack_req <= 1'b1;
        tick(3);
        chk(host_access_ack_oe, s[2]);
        if (s[2]) chk(host_access_ack_o, 1'b1);
        host_ack_req <= 1'b0;
        tick(3);
        chk(host_access_ack_oe, s[2] & ~s[3]);
        if (s[2]) chk(host_access_ack_o, s[3]);
    endtask

    initial begin
        rst_n = 1'b0;
        hold_reset = 1'b1;
        strap = 4'h0;
        gap = 2'h1;
        {bus_request, internal_dma_port_write, internal_dma_port_addr_zero, host_ack_req} = 4'h0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        tick(16);
        rst_n <= 1'b1;
        tick(40);
        rdchk(ADDR_CTRL, 32'(CTRL_RESET));
        for (int m = 0; m < 6; m++) run_mode(modes[m]);
        bus(1'b1, ADDR_CTRL, 32'h0000_0001);
        tick(2);
        chk(cycle_clock_out, 1'b0);
        toggles(0);
        bus(1'b1, ADDR_CTRL, 32'h0000_000E);
        tick(2);
        toggles(8);
        chk({six_irq_mode, flag_pin_two_oe, flag_pin_two_o}, 3'h7);
        rdchk(ADDR_CTRL, 32'h0000_000E);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        rdchk(4'h2, READ_ZERO);
        rdchk(ADDR_CTRL, 32'h0000_000E);
        bus(1'b1, ADDR_CTRL, 32'h0000_0004);
        tick(2);
        chk({six_irq_mode, flag_pin_two_oe, flag_pin_two_o}, 3'h2);
        bus(1'b1, ADDR_IMASK, 32'h0000_0155);
        rdchk(ADDR_IMASK, 32'h0000_0155);
        chk(imask, 10'h155);
        bus(1'b1, ADDR_STATUS, 32'h0000_0000);
        rdchk(ADDR_STATUS, {23'h0, ST_RUN, 1'b1, 1'b1, 4'hD});
        summarize();
    end
endmodule // tb_top
`default_nettype wire
